/* src/rftxd_consts.vh */
`ifndef RFTXD_CONSTS_VH
`define RFTXD_CONSTS_VH
// Register byte offsets
`define RFTXD_OFF_CTRL      8'h00
`define RFTXD_OFF_PCOND     8'h04
`define RFTXD_OFF_NCOND_ON  8'h08
`define RFTXD_OFF_NCOND_OFF 8'h0c
`define RFTXD_OFF_FRAMING   8'h10
`define RFTXD_OFF_AUTO      8'h14
`define RFTXD_OFF_STATUS    8'h18
// Control register fields
`define RFTXD_CTRL_CARRIER_EN 0
`define RFTXD_CTRL_FORCE_FULL 1
`define RFTXD_CTRL_ON_INVERT  2
`define RFTXD_CTRL_IDLE_LEVEL 3
`define RFTXD_CTRL_SECOND_ON  4
`define RFTXD_CTRL_W          5
// Conductance fields: steady [5:0], keyed [13:8]
`define RFTXD_COND_W          6
`define RFTXD_STEADY_LSB      0
`define RFTXD_KEYED_LSB       8
// Framing register: rate field [5:4], frame type [1:0]
`define RFTXD_RATE_LSB        4
`define RFTXD_RATE_106        2'h0
`define RFTXD_RATE_212        2'h1
`define RFTXD_RATE_424        2'h2
`define RFTXD_RATE_RSVD       2'h3
`define RFTXD_FRAME_LSB       0
// Reset values
`define RFTXD_CTRL_RST        5'h00
`define RFTXD_COND_RST        6'h20
`define RFTXD_FRAMING_RST     8'h00
`define RFTXD_AUTO_RST        8'h00
// AXI responses
`define RFTXD_RESP_OKAY       2'h0
`define RFTXD_RESP_SLVERR     2'h2
`endif

/* src/rftxd_top.v */
// Contract
// - Carrier is crystal halved, plus inverted copy
// - Carrier off: output equals idle level
// - Off, low: NMOS keyed/steady field-off by envelope
// - Carrier on: invert bit picks phase
// - On, no force: envelope picks keyed/steady
// - Forced keying: envelope low grounds output
// - Second NMOS: copies first if second-on, else field-on values
// - Depth set by programmable driver conductances
// - Rate, framing from one config register (framing)
// - Type B rates 106, 212, 424
// - Unit builds framing up to 424; here rate and frame type only go out on TX_RATE, TX_FRAME_TYPE
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`include "rftxd_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module rftxd_top (
    // Clock and reset
    input  wire        CORE_CLK,
    input  wire        RESET_N,
    // Crystal clock and envelope (asynchronous pins)
    input  wire        CRYSTAL_CLK,
    input  wire        ENVELOPE,
    // Antenna output and driver settings
    output reg         FIRST_ANTENNA_OUTPUT,
    output reg         CARRIER,
    output reg         INVERTED_CARRIER,
    output reg  [5:0]  PMOS_COND,
    output reg         PMOS_ACTIVE,
    output reg  [5:0]  NMOS_COND,
    output reg         NMOS_ACTIVE,
    output reg  [5:0]  SECOND_NMOS_COND,
    output reg  [1:0]  TX_RATE,
    output reg  [1:0]  TX_FRAME_TYPE,
    // AXI4-Lite write address
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    // AXI4-Lite write response
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    // AXI4-Lite read data
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [4:0]  ctrl_ff;
reg  [13:0] pcond_ff;
reg  [13:0] ncond_on_ff;
reg  [13:0] ncond_off_ff;
reg  [7:0]  framing_ff;
reg  [7:0]  auto_ff;
reg  [7:0]  aw_addr_ff;
reg         aw_held_ff;
reg  [31:0] w_data_ff;
reg  [3:0]  w_strb_ff;
reg         w_held_ff;
reg         envelope_ff;

// Byte-lane merge, used by every writable register
function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = data[i*8 +: 8];
            end
        end
    end
endfunction

function mapped;
    input [7:0] addr;
    begin
        mapped = (addr[7:2] <= (`RFTXD_OFF_STATUS >> 2)) &&
                 (addr[1:0] == 2'h0);
    end
endfunction

wire [7:0]  wr_addr = aw_held_ff ? aw_addr_ff : S_AXI_AWADDR;
wire [31:0] wr_data = w_held_ff ? w_data_ff : S_AXI_WDATA;
wire [3:0]  wr_strb = w_held_ff ? w_strb_ff : S_AXI_WSTRB;
wire aw_ok = aw_held_ff || (S_AXI_AWVALID && S_AXI_AWREADY);
wire w_ok  = w_held_ff || (S_AXI_WVALID && S_AXI_WREADY);
wire wr_go = aw_ok && w_ok && !S_AXI_BVALID;
wire [31:0] ctrl_new      = merge({27'h0, ctrl_ff}, wr_data, wr_strb);
wire [31:0] pcond_new     = merge({18'h0, pcond_ff}, wr_data, wr_strb);
wire [31:0] ncond_on_new  = merge({18'h0, ncond_on_ff}, wr_data, wr_strb);
wire [31:0] ncond_off_new = merge({18'h0, ncond_off_ff}, wr_data, wr_strb);
wire [31:0] framing_new   = merge({24'h0, framing_ff}, wr_data, wr_strb);
wire [31:0] auto_new      = merge({24'h0, auto_ff}, wr_data, wr_strb);

////////////////////////////////////////////////////////////////////////////////
// Write channel: address and data in either order, response after both

always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
        S_AXI_AWREADY <= 1'b0;
        S_AXI_WREADY  <= 1'b0;
        S_AXI_BVALID  <= 1'b0;
        S_AXI_BRESP   <= `RFTXD_RESP_OKAY;
        aw_held_ff    <= 1'b0;
        w_held_ff     <= 1'b0;
        aw_addr_ff    <= 8'h00;
        w_data_ff     <= 32'h0;
        w_strb_ff     <= 4'h0;
        ctrl_ff       <= `RFTXD_CTRL_RST;
        pcond_ff      <= {`RFTXD_COND_RST, 2'h0, `RFTXD_COND_RST};
        ncond_on_ff   <= {`RFTXD_COND_RST, 2'h0, `RFTXD_COND_RST};
        ncond_off_ff  <= {`RFTXD_COND_RST, 2'h0, `RFTXD_COND_RST};
        framing_ff    <= `RFTXD_FRAMING_RST;
        auto_ff       <= `RFTXD_AUTO_RST;
    end else begin
        // Readies stay low while a response waits
        S_AXI_AWREADY <= !aw_ok && !S_AXI_AWREADY && !S_AXI_BVALID;
        S_AXI_WREADY  <= !w_ok && !S_AXI_WREADY && !S_AXI_BVALID;
        if (S_AXI_AWVALID && S_AXI_AWREADY && !wr_go) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY && !wr_go) begin
            w_held_ff <= 1'b1;
            w_data_ff <= S_AXI_WDATA;
            w_strb_ff <= S_AXI_WSTRB;
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
        if (wr_go) begin
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b1;
            S_AXI_BRESP   <= (mapped(wr_addr) &&
                              wr_addr != `RFTXD_OFF_STATUS) ?
                             `RFTXD_RESP_OKAY : `RFTXD_RESP_SLVERR;
            case (wr_addr)
                `RFTXD_OFF_CTRL:      ctrl_ff <= ctrl_new[4:0];
                `RFTXD_OFF_PCOND:     pcond_ff <= pcond_new[13:0] & 14'h3f3f;
                `RFTXD_OFF_NCOND_ON:  ncond_on_ff <= ncond_on_new[13:0] &
                                                     14'h3f3f;
                `RFTXD_OFF_NCOND_OFF: ncond_off_ff <= ncond_off_new[13:0] &
                                                      14'h3f3f;
                `RFTXD_OFF_FRAMING:   framing_ff <= framing_new[7:0];
                `RFTXD_OFF_AUTO:      auto_ff <= auto_new[7:0];
                default:              auto_ff <= auto_ff;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel: one cycle after address acceptance

reg [31:0] rd_mux;
always @* begin
    rd_mux = 32'h0;
    case (S_AXI_ARADDR)
        `RFTXD_OFF_CTRL:      rd_mux = {27'h0, ctrl_ff};
        `RFTXD_OFF_PCOND:     rd_mux = {18'h0, pcond_ff};
        `RFTXD_OFF_NCOND_ON:  rd_mux = {18'h0, ncond_on_ff};
        `RFTXD_OFF_NCOND_OFF: rd_mux = {18'h0, ncond_off_ff};
        `RFTXD_OFF_FRAMING:   rd_mux = {24'h0, framing_ff};
        `RFTXD_OFF_AUTO:      rd_mux = {24'h0, auto_ff};
        `RFTXD_OFF_STATUS:    rd_mux = {24'h0, NMOS_ACTIVE, PMOS_ACTIVE,
                                        2'h0, envelope_ff,
                                        INVERTED_CARRIER, CARRIER,
                                        FIRST_ANTENNA_OUTPUT};
        default:              rd_mux = 32'h0;
    endcase
end

always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b0;
        S_AXI_RDATA   <= 32'h0;
        S_AXI_RRESP   <= `RFTXD_RESP_OKAY;
    end else begin
        S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID &&
                         S_AXI_ARVALID;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_mux;
            S_AXI_RRESP  <= mapped(S_AXI_ARADDR) ?
                            `RFTXD_RESP_OKAY : `RFTXD_RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers, three stages; change counts once stages 2 and 3 agree

reg  [2:0] xtal_sync_ff;
reg  [2:0] env_sync_ff;
reg        xtal_ff;
reg        half_ff;

always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
        xtal_sync_ff <= 3'h0;
        env_sync_ff  <= 3'h0;
        envelope_ff  <= 1'b1;
        xtal_ff      <= 1'b0;
        half_ff      <= 1'b0;
    end else begin
        xtal_sync_ff <= {xtal_sync_ff[1:0], CRYSTAL_CLK};
        env_sync_ff  <= {env_sync_ff[1:0], ENVELOPE};
        if (env_sync_ff[1] == env_sync_ff[2]) begin
            envelope_ff <= env_sync_ff[2];
        end
        if (xtal_sync_ff[1] == xtal_sync_ff[2]) begin
            xtal_ff <= xtal_sync_ff[2];
        end
        if (xtal_ff == 1'b0 && xtal_sync_ff[1] == xtal_sync_ff[2] &&
            xtal_sync_ff[2] == 1'b1) begin
            half_ff <= !half_ff;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// First output selection and conductance choice

wire carrier_en = ctrl_ff[`RFTXD_CTRL_CARRIER_EN];
wire force_full = ctrl_ff[`RFTXD_CTRL_FORCE_FULL];
wire on_invert  = ctrl_ff[`RFTXD_CTRL_ON_INVERT];
wire idle_level = ctrl_ff[`RFTXD_CTRL_IDLE_LEVEL];
wire second_on  = ctrl_ff[`RFTXD_CTRL_SECOND_ON];
wire [5:0] p_steady   = pcond_ff[`RFTXD_STEADY_LSB +: 6];
wire [5:0] p_keyed    = pcond_ff[`RFTXD_KEYED_LSB +: 6];
wire [5:0] non_steady = ncond_on_ff[`RFTXD_STEADY_LSB +: 6];
wire [5:0] non_keyed  = ncond_on_ff[`RFTXD_KEYED_LSB +: 6];
wire [5:0] noff_stdy  = ncond_off_ff[`RFTXD_STEADY_LSB +: 6];
wire [5:0] noff_keyed = ncond_off_ff[`RFTXD_KEYED_LSB +: 6];
wire       phase      = on_invert ? !half_ff : half_ff;

reg        nxt_out;
reg  [5:0] nxt_pcond;
reg        nxt_pact;
reg  [5:0] nxt_ncond;
reg        nxt_nact;
reg  [5:0] nxt_second;

always @* begin
    nxt_out   = 1'b0;
    nxt_pcond = 6'h00;
    nxt_pact  = 1'b0;
    nxt_ncond = 6'h00;
    nxt_nact  = 1'b0;
    if (!carrier_en) begin
        nxt_out = idle_level;
        if (idle_level) begin
            nxt_pact  = 1'b1;
            nxt_pcond = envelope_ff ? p_steady : p_keyed;
        end else begin
            nxt_nact  = 1'b1;
            nxt_ncond = envelope_ff ? noff_stdy : noff_keyed;
        end
    end else if (force_full && !envelope_ff) begin
        nxt_out   = 1'b0;
        nxt_nact  = 1'b1;
        nxt_ncond = non_keyed;
    end else begin
        nxt_out   = phase;
        nxt_pact  = 1'b1;
        nxt_nact  = 1'b1;
        nxt_pcond = envelope_ff ? p_steady : p_keyed;
        nxt_ncond = envelope_ff ? non_steady : non_keyed;
    end
    nxt_second = second_on ? nxt_ncond :
                 (envelope_ff ? non_steady : non_keyed);
end

always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
        FIRST_ANTENNA_OUTPUT <= 1'b0;
        CARRIER              <= 1'b0;
        INVERTED_CARRIER     <= 1'b1;
        PMOS_COND            <= 6'h00;
        PMOS_ACTIVE          <= 1'b0;
        NMOS_COND            <= 6'h00;
        NMOS_ACTIVE          <= 1'b0;
        SECOND_NMOS_COND     <= 6'h00;
        TX_RATE              <= `RFTXD_RATE_106;
        TX_FRAME_TYPE        <= 2'h0;
    end else begin
        FIRST_ANTENNA_OUTPUT <= nxt_out;
        CARRIER              <= half_ff;
        INVERTED_CARRIER     <= !half_ff;
        PMOS_COND            <= nxt_pcond;
        PMOS_ACTIVE          <= nxt_pact;
        NMOS_COND            <= nxt_ncond;
        NMOS_ACTIVE          <= nxt_nact;
        SECOND_NMOS_COND     <= nxt_second;
        // rates; reserved code falls back to 106
        TX_RATE <= (framing_ff[`RFTXD_RATE_LSB +: 2] == `RFTXD_RATE_RSVD) ?
                   `RFTXD_RATE_106 : framing_ff[`RFTXD_RATE_LSB +: 2];
        TX_FRAME_TYPE        <= framing_ff[`RFTXD_FRAME_LSB +: 2];
    end
end

endmodule
`default_nettype wire

/* verification/rftxd_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rftxd_chk (
    // Clock, reset, crystal
    input wire logic        CORE_CLK, RESET_N, CRYSTAL_CLK,
    // Antenna drive
    input wire logic        FIRST_ANTENNA_OUTPUT, CARRIER,
    input wire logic        INVERTED_CARRIER, PMOS_ACTIVE, NMOS_ACTIVE,
    // Register bus
    input wire logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID,
    input wire logic        S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic [31:0] S_AXI_RDATA
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    wire both_on = PMOS_ACTIVE && NMOS_ACTIVE;
    ////////////////////////////////////////////////////////////////////////
    a_carrier_pair: assert property (INVERTED_CARRIER == !CARRIER)
        else $error("inverted carrier not complement");
    a_crystal_halve: assert property ($rose(CRYSTAL_CLK)
        |-> ##[1:6] $changed(CARRIER)) else $error("carrier missed edge");
    a_low_only_n: assert property (NMOS_ACTIVE && !PMOS_ACTIVE
        |-> !FIRST_ANTENNA_OUTPUT) else $error("nmos only but output high");
    a_high_only_p: assert property (PMOS_ACTIVE && !NMOS_ACTIVE
        |-> FIRST_ANTENNA_OUTPUT) else $error("pmos only but output low");
    // Phase may land with the carrier or one cycle later
    a_on_follows: assert property (both_on && $past(both_on)
        && $changed(CARRIER) |-> ##[0:1] $changed(FIRST_ANTENNA_OUTPUT))
        else $error("output ignores carrier");
    a_b_after_data: assert property (S_AXI_AWVALID && S_AXI_AWREADY
        && S_AXI_WVALID && S_AXI_WREADY |=> S_AXI_BVALID)
        else $error("write response late");
    a_b_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY
        |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bvalid lost");
    a_b_quiet: assert property (S_AXI_BVALID
        |-> !S_AXI_AWREADY && !S_AXI_WREADY) else $error("ready in response");
    a_r_after_ar: assert property (S_AXI_ARVALID && S_AXI_ARREADY
        |=> S_AXI_RVALID) else $error("read data late");
    a_r_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rvalid lost");
    c_forced: cover property (NMOS_ACTIVE && !PMOS_ACTIVE && $past(both_on));
    c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
    c_read: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule
bind rftxd_top rftxd_chk u_chk (.*);
`default_nettype wire

/* verification/rftxd_antenna.sv */
`timescale 1ns/1ps
`default_nettype none
module rftxd_antenna (
    // Clock and reset
    input  wire logic       clk, rst_n,
    // Driver pins seen by the tank
    input  wire logic       drive, p_on, n_on,
    // Field swings counted
    output var  logic [7:0] swings_ff
);
    logic last_ff;
    // Only a push-pull pair rings the tank
    always @(posedge clk) begin
        last_ff <= drive;
        if (!rst_n) begin
            swings_ff <= 8'h00;
        end else if (drive != last_ff && p_on && n_on) begin
            swings_ff <= swings_ff + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`include "rftxd_consts.vh"
`default_nettype none
module tb;
    logic        CORE_CLK = 1'b0, RESET_N = 1'b0;
    logic        CRYSTAL_CLK = 1'b0, ENVELOPE = 1'b1;
    logic        FIRST_ANTENNA_OUTPUT, CARRIER, INVERTED_CARRIER;
    logic        PMOS_ACTIVE, NMOS_ACTIVE, S_AXI_AWREADY, S_AXI_WREADY;
    logic [5:0]  PMOS_COND, NMOS_COND, SECOND_NMOS_COND;
    logic [1:0]  TX_RATE, TX_FRAME_TYPE, S_AXI_BRESP, S_AXI_RRESP;
    logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00, swings;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic [3:0]  S_AXI_WSTRB = 4'hf;
    logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
    logic        S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0;
    logic        S_AXI_RREADY = 1'b0, S_AXI_BVALID, S_AXI_ARREADY;
    logic        S_AXI_RVALID, smp = 1'b0, ph = 1'b0;
    logic [15:0] rnd = 16'h849b;
    logic [53:0] oq[$], o;
    logic [67:0] rq[$], r;
    logic [1:0]  bq[$];
    int          errors = 0, num_checks = 0, cyc = 0;
    rftxd_top uut (.*);
    rftxd_antenna tank (.clk(CORE_CLK), .rst_n(RESET_N),
        .drive(FIRST_ANTENNA_OUTPUT), .p_on(PMOS_ACTIVE), .n_on(NMOS_ACTIVE),
        .swings_ff(swings));
    always #4 CORE_CLK = !CORE_CLK;
    ////////////////////////////////////////////////////////////////////////
    function automatic [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input [33:0] seen, exp, input string nm);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input [7:0] a, input [31:0] d, input [1:0] rs);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        bq.push_back(rs);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge CORE_CLK);
            if (S_AXI_AWREADY) ad = 1'b1;
            if (S_AXI_WREADY) wd = 1'b1;
            if (ad) S_AXI_AWVALID <= 1'b0;
            if (wd) S_AXI_WVALID <= 1'b0;
        end
        // Late ready so the response is seen waiting
        @(posedge CORE_CLK);
        S_AXI_BREADY <= 1'b1;
        do @(posedge CORE_CLK); while (!S_AXI_BVALID);
        S_AXI_BREADY <= 1'b0;
    endtask
    task automatic rd(input [7:0] a, input [33:0] e, m);
        rq.push_back({m, e});
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        do @(posedge CORE_CLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'b0;
        @(posedge CORE_CLK);
        S_AXI_RREADY <= 1'b1;
        do @(posedge CORE_CLK); while (!S_AXI_RVALID);
        S_AXI_RREADY <= 1'b0;
    endtask
    task automatic xtal;
        CRYSTAL_CLK <= 1'b1;
        repeat (6) @(posedge CORE_CLK);
        CRYSTAL_CLK <= 1'b0;
        repeat (6) @(posedge CORE_CLK);
        ph = !ph;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge CORE_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            give_verdict;
        end
        if (S_AXI_BVALID && S_AXI_BREADY)
            chk({32'h0, S_AXI_BRESP}, {32'h0, bq.pop_front()}, "bresp");
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            r = rq.pop_front();
            chk({S_AXI_RRESP, S_AXI_RDATA} & r[67:34], r[33:0], "rd");
        end
        if (smp) begin
            o = oq.pop_front();
            chk({7'h0, FIRST_ANTENNA_OUTPUT, CARRIER, INVERTED_CARRIER,
                PMOS_ACTIVE, NMOS_ACTIVE, PMOS_COND, NMOS_COND,
                SECOND_NMOS_COND, TX_RATE, TX_FRAME_TYPE} & {7'h0, o[53:27]},
                {7'h0, o[26:0]}, "drive");
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] pw, nw, fw;
        logic [26:0] ev, m;
        logic [7:0]  s0;
        repeat (4) @(posedge CORE_CLK);
        RESET_N <= 1'b1;
        @(posedge CORE_CLK);
        for (int i = 0; i < 6; i++)
            rd(8'(4 * i), (i > 0 && i < 4) ? 34'h2020 : 34'h0, '1);
        wr(`RFTXD_OFF_STATUS, 32'h0, `RFTXD_RESP_SLVERR);
        wr(8'h20, 32'h0, `RFTXD_RESP_SLVERR);
        rd(8'h1c, {`RFTXD_RESP_SLVERR, 32'h0}, '1);
        for (int c = 0; c < 16; c++) begin
            rnd = lfsr(rnd);
            pw = rnd & 16'h3f3f;
            nw = lfsr(rnd) & 16'h3f3f;
            fw = {rnd[7:0], rnd[15:8]} & 16'h3f3f;
            // depth is software's choice; raw values here
            wr(`RFTXD_OFF_PCOND, {16'h0, pw}, 2'h0);
            wr(`RFTXD_OFF_NCOND_ON, {16'h0, nw}, 2'h0);
            wr(`RFTXD_OFF_NCOND_OFF, {16'h0, fw}, 2'h0);
            wr(`RFTXD_OFF_FRAMING, {26'h0, c[1:0], 2'h0, rnd[1:0]}, 2'h0);
            wr(`RFTXD_OFF_CTRL, {28'h0, c[3:0]}, 2'h0);
            rd(`RFTXD_OFF_PCOND, {18'h0, pw}, '1);
            xtal;
            for (int e = 0; e < 2; e++) begin
                ENVELOPE <= e[0];
                repeat (8) @(posedge CORE_CLK);
                m = 27'h7ffffff;
                if (!c[0]) begin
                    ev = {c[3], ph, !ph, c[3], !c[3], e ? pw[5:0] : pw[13:8],
                          e ? fw[5:0] : fw[13:8], 10'h0};
                    m = c[3] ? 27'h7ff000f : 27'h7c0fc0f;
                end else if (c[1] && e == 0) begin
                    ev = {1'b0, ph, !ph, 2'b01, 6'h0, nw[13:8], nw[13:8], 4'h0};
                end else begin
                    ev = {ph ^ c[2], ph, !ph, 2'b11, e ? pw[5:0] : pw[13:8],
                          e ? nw[5:0] : nw[13:8], e ? nw[5:0] : nw[13:8], 4'h0};
                end
                // reserved rate falls back to 106
                ev[3:0] = {c[1:0] == 2'h3 ? 2'h0 : c[1:0], rnd[1:0]};
                oq.push_back({m, ev & m});
                smp <= 1'b1;
                @(posedge CORE_CLK);
                smp <= 1'b0;
            end
        end
        wr(`RFTXD_OFF_CTRL, 32'h1, 2'h0);
        ENVELOPE <= 1'b1;
        repeat (8) @(posedge CORE_CLK);
        s0 = swings;
        repeat (4) xtal;
        repeat (8) @(posedge CORE_CLK);
        chk({26'h0, swings - s0}, 34'h4, "swings");
        give_verdict;
    end
endmodule
`default_nettype wire
